//--- core/csm_map.svh
`ifndef CSM_MAP_SVH
`define CSM_MAP_SVH

// serial word: data in the upper bits, register number in the low bits
`define CSM_WORD_W 32
`define CSM_ADDR_MSB 4
`define CSM_REG_MODE_SYNC 5'h0B
`define CSM_REG_LOCK_PIN 5'h0C
`define CSM_REG_DELAY_LAST 5'h05

// mode and sync control fields
`define CSM_MODE_MSB 31
`define CSM_MODE_LSB 27
`define CSM_EN_SYNC_BIT 26
`define CSM_MASK_MSB 25
`define CSM_MASK_LSB 20
`define CSM_SYNC_SRC_MSB 19
`define CSM_SYNC_SRC_LSB 18
`define CSM_QUAL_BIT 17
`define CSM_POL_BIT 16
`define CSM_AUTO_BIT 15
`define CSM_SYNC_TYPE_MSB 14
`define CSM_SYNC_TYPE_LSB 12
`define CSM_OSC_AMP_BIT 5

// lock status pin fields
`define CSM_LD_SRC_MSB 31
`define CSM_LD_SRC_LSB 27
`define CSM_LOCK_PIN_TYPE_MSB 26
`define CSM_LOCK_PIN_TYPE_LSB 24

`define CSM_MODE_SYNC_RESET 32'h0400_0000
`define CSM_LOCK_PIN_RESET 32'h0300_0000

// operating modes
`define CSM_MODE_DUAL_INT 5'h00
`define CSM_MODE_DUAL_INT_ZD 5'h02
`define CSM_MODE_DUAL_EXT 5'h03
`define CSM_MODE_DUAL_EXT_ZD 5'h05
`define CSM_MODE_SINGLE_INT 5'h06
`define CSM_MODE_SINGLE_INT_ZD 5'h08
`define CSM_MODE_SINGLE_EXT 5'h0B
`define CSM_MODE_DIST 5'h10

// pin types
`define CSM_PIN_IN 3'h0
`define CSM_PIN_IN_PU 3'h1
`define CSM_PIN_IN_PD 3'h2
`define CSM_PIN_OUT 3'h3
`define CSM_PIN_OUT_INV 3'h4
`define CSM_PIN_OUT_OSRC 3'h5
`define CSM_PIN_OUT_ODRN 3'h6

`define CSM_SYNC_SRC_LOW 2'h0
`define CSM_SYNC_SRC_READBACK 2'h3
`define CSM_LD_SRC_LAST 5'h12
`define CSM_OUT_COUNT 6

// timing
`define CSM_CLK_PERIOD_NS 50
`define CSM_SYNC_PULSE_NS 200
`define CSM_SYNC_PULSE_CYC ((`CSM_SYNC_PULSE_NS + `CSM_CLK_PERIOD_NS - 1) / `CSM_CLK_PERIOD_NS)

`endif

//--- core/csm_pkg.sv
`default_nettype none
package csm_pkg;

    typedef enum logic [1:0]
    {
        CSM_ST_IDLE,
        CSM_ST_START_ALIGN,
        CSM_ST_HOLD,
        CSM_ST_END_ALIGN
    } csm_sync_state_t;

    typedef logic [2:0] csm_pin_type_t;

endpackage : csm_pkg
`default_nettype wire

//--- core/csm_serial_rx.sv
`include "csm_map.svh"
`default_nettype none
module csm_serial_rx
(
    input wire logic serialClk,
    input wire logic rst_n,
    input wire logic serialData,
    output logic [`CSM_WORD_W-1:0] shiftWord
);

    // msb first; the host stops the clock while latch enable is high,
    // so the word is quiet when the system side copies it
    always_ff @(posedge serialClk or negedge rst_n)
    begin
        if (!rst_n)
            shiftWord <= '0;
        else
            shiftWord <= {shiftWord[`CSM_WORD_W-2:0], serialData};
    end

endmodule : csm_serial_rx
`default_nettype wire

//--- core/csm_top.sv
`include "csm_map.svh"
`default_nettype none
// Notes on behaviour
// R01 - mode field decodes dual, single, distribution, oscillator and zero-delay variants; the code decodes no oscillator mode
// R02 - single loop powers down first loop, reference from oscillator input
// R03 - distribution routes second clock input to outputs, oscillator to oscillator output
// R04 - sync enable resets set; cleared means no sync at all
// R05 - sync enable rising edge fires a sync on unmasked outputs
// R06 - mask bit set keeps that output running through a sync
// R07 - participating outputs held low during a sync event
// R08 - new digital delay applies only at a sync, unmasked outputs only
// R09 - setting a mask leaves existing alignment alone
// R10 - sync pin output source: 0 low, 3 readback
// R11 - pin type 3 drives true, type 4 inverted
// R12 - qualification times sync start and end to selected output
// R13 - software keeps output two divider powered when qualifying
// R14 - polarity bit sets sync pin sense; asserted pin holds outputs low
// R15 - toggling polarity bit by serial write produces a sync
// R16 - auto sync: writes to registers zero to five sync at latch fall
// R17 - three-bit pin type configures sync pin input, pulls and output kinds
// R18 - output pin type forces internal sync input to zero
// R19 - oscillator amplifier enable powers the crystal feedback amplifier
// R20 - five-bit selector picks lock status pin source
// R21 - lock pin type 3 active high, 4 active low
// R22 - software avoids second loop reference divider on lock pin in conflicts
// R23 - software never writes reserved codes
module csm_top
    import csm_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic serialClk,
    input wire logic serialData,
    input wire logic serialLatchEnable,
    input wire logic syncPinIn,
    input wire logic [5:0] qualClk,
    input wire logic [2:0] feedbackSelect,
    input wire logic [1:0] lockDetect,
    input wire logic holdoverStatus,
    input wire logic [3:0] converterStatus,
    input wire logic [7:0] loopDividerTap,
    input wire logic readbackData,
    output logic firstLoopPowerDown,
    output logic secondLoopPowerDown,
    output logic refFromOscInput,
    output logic distributionMode,
    output logic zeroDelayEnable,
    output logic externalVcoSelect,
    output logic modeReserved,
    output logic oscAmpEnable,
    output logic syncEnable,
    output logic [5:0] outputHoldLow,
    output logic [5:0] delayApply,
    output logic syncPinOut,
    output logic syncPinOe_n,
    output logic syncPinPullUp,
    output logic syncPinPullDown,
    output logic lockPinOut,
    output logic lockPinOe_n
);

    localparam int SYNC_W = 24;
    localparam logic [2:0] PULSE_LAST = 3'(`CSM_SYNC_PULSE_CYC - 1);

    function automatic logic isOutputType(input csm_pin_type_t t);
        return (t >= `CSM_PIN_OUT) && (t <= `CSM_PIN_OUT_ODRN);
    endfunction : isOutputType

    // open kinds drive only one level and float the other
    function automatic logic pinOeN(input csm_pin_type_t t, input logic v);
        logic oe;
        oe = 1'b1;
        case (t)
            `CSM_PIN_OUT, `CSM_PIN_OUT_INV: oe = 1'b0;
            `CSM_PIN_OUT_OSRC: oe = !v;
            `CSM_PIN_OUT_ODRN: oe = v;
            default: oe = 1'b1;
        endcase
        return oe;
    endfunction : pinOeN

    function automatic logic pinLevel(input csm_pin_type_t t, input logic src);
        return (t == `CSM_PIN_OUT_INV) ? !src : src;
    endfunction : pinLevel

    // two-flop synchronisers for latch enable, sync pin, readback, qualifying clock and status inputs
    logic [SYNC_W-1:0] rawIn;
    logic [SYNC_W-1:0] syncA;
    logic [SYNC_W-1:0] syncB;
    assign rawIn = {serialLatchEnable, syncPinIn, readbackData, qualClk, lockDetect,
                    holdoverStatus, converterStatus, loopDividerTap};

    genvar gi;
    generate
        for (gi = 0; gi < SYNC_W; gi++)
        begin : g_sync
            always_ff @(posedge clk_sys or negedge rst_n)
            begin
                if (!rst_n)
                begin
                    syncA[gi] <= 1'b0;
                    syncB[gi] <= 1'b0;
                end
                else
                begin
                    syncA[gi] <= rawIn[gi];
                    syncB[gi] <= syncA[gi];
                end
            end
        end
    endgenerate

    wire leS = syncB[23];
    wire pinS = syncB[22];
    wire readbackS = syncB[21];
    wire [5:0] qualS = syncB[20:15];
    wire [1:0] lockS = syncB[14:13];
    wire holdS = syncB[12];
    wire [3:0] convS = syncB[11:8];
    wire [7:0] tapS = syncB[7:0];

    logic [`CSM_WORD_W-1:0] shiftWord;
    csm_serial_rx u_rx
    (
        .serialClk(serialClk),
        .rst_n(rst_n),
        .serialData(serialData),
        .shiftWord(shiftWord)
    );

    logic leD;
    logic pendingAuto;
    logic reqPulse;
    logic qualPrev;
    logic holdActive;
    logic [2:0] cnt;
    logic [31:0] regModeSync;
    logic [31:0] regLockPin;
    csm_sync_state_t state;

    wire leRise = leS && !leD;
    wire leFall = !leS && leD;
    wire [`CSM_ADDR_MSB:0] wordAddr = shiftWord[`CSM_ADDR_MSB:0];
    wire wrModeSync = leRise && (wordAddr == `CSM_REG_MODE_SYNC);
    wire wrLockPin = leRise && (wordAddr == `CSM_REG_LOCK_PIN);
    wire wrDelay = leRise && (wordAddr <= `CSM_REG_DELAY_LAST);

    wire [4:0] modeField = regModeSync[`CSM_MODE_MSB:`CSM_MODE_LSB];
    wire enSyncBit = regModeSync[`CSM_EN_SYNC_BIT];
    wire [5:0] maskField = regModeSync[`CSM_MASK_MSB:`CSM_MASK_LSB];
    wire [1:0] syncSrcField = regModeSync[`CSM_SYNC_SRC_MSB:`CSM_SYNC_SRC_LSB];
    wire qualBit = regModeSync[`CSM_QUAL_BIT];
    wire polBit = regModeSync[`CSM_POL_BIT];
    wire autoBit = regModeSync[`CSM_AUTO_BIT];
    wire csm_pin_type_t syncTypeField = regModeSync[`CSM_SYNC_TYPE_MSB:`CSM_SYNC_TYPE_LSB];
    wire oscAmpBit = regModeSync[`CSM_OSC_AMP_BIT];
    wire [4:0] ldSrcField = regLockPin[`CSM_LD_SRC_MSB:`CSM_LD_SRC_LSB];
    wire csm_pin_type_t ldTypeField = regLockPin[`CSM_LOCK_PIN_TYPE_MSB:`CSM_LOCK_PIN_TYPE_LSB];

    // R01 mode decode
    wire isDualInt = (modeField == `CSM_MODE_DUAL_INT) || (modeField == `CSM_MODE_DUAL_INT_ZD);
    wire isDualExt = (modeField == `CSM_MODE_DUAL_EXT) || (modeField == `CSM_MODE_DUAL_EXT_ZD);
    wire isSingleInt = (modeField == `CSM_MODE_SINGLE_INT) || (modeField == `CSM_MODE_SINGLE_INT_ZD);
    wire isSingleExt = modeField == `CSM_MODE_SINGLE_EXT;
    wire isDist = modeField == `CSM_MODE_DIST;
    wire isZeroDelay = (modeField == `CSM_MODE_DUAL_INT_ZD) || (modeField == `CSM_MODE_DUAL_EXT_ZD)
                       || (modeField == `CSM_MODE_SINGLE_INT_ZD);
    wire isSingle = isSingleInt || isSingleExt;
    wire isKnown = isDualInt || isDualExt || isSingle || isDist;
    // R02 single loop drops the first loop
    wire next_firstLoopPowerDown = isSingle || isDist;
    // R03 distribution bypasses both loops
    wire next_secondLoopPowerDown = isDist;
    wire next_refFromOscInput = isSingle;
    wire next_externalVco = isDualExt || isSingleExt;

    // R05 enable rising edge fires a sync
    wire enRise = wrModeSync && !enSyncBit && shiftWord[`CSM_EN_SYNC_BIT];
    // R15 polarity toggle fires a sync
    wire polToggle = wrModeSync && (shiftWord[`CSM_POL_BIT] != polBit);
    // R16 auto sync lands on latch enable fall
    wire autoFire = leFall && pendingAuto && autoBit;
    wire next_req = enRise || polToggle || autoFire;

    // R18 output type reads the pin as zero
    wire syncOutType = isOutputType(syncTypeField);
    wire pinInternal = syncOutType ? 1'b0 : pinS;
    // R14 polarity sets the active sense
    wire pinAsserted = pinInternal ^ polBit;
    wire syncDemand = reqPulse || pinAsserted;

    // R12 qualifying edge from the selected output
    wire qualSel = (feedbackSelect < 3'h6) ? qualS[feedbackSelect] : 1'b0;
    wire qualEdge = qualSel && !qualPrev;

    csm_sync_state_t next_state;
    logic [2:0] next_cnt;
    logic finishing;

    always_comb
    begin
        next_state = state;
        next_cnt = cnt;
        finishing = 1'b0;
        // R04 disabled sync aborts and ignores requests
        if (!enSyncBit)
            next_state = CSM_ST_IDLE;
        else
        begin
            case (state)
                CSM_ST_IDLE:
                begin
                    if (syncDemand)
                    begin
                        next_cnt = PULSE_LAST;
                        next_state = qualBit ? CSM_ST_START_ALIGN : CSM_ST_HOLD;
                    end
                end
                CSM_ST_START_ALIGN:
                begin
                    if (qualEdge)
                    begin
                        next_cnt = PULSE_LAST;
                        next_state = CSM_ST_HOLD;
                    end
                end
                CSM_ST_HOLD:
                begin
                    if (syncDemand)
                        next_cnt = PULSE_LAST;
                    else if (cnt != 3'h0)
                        next_cnt = cnt - 3'h1;
                    else if (qualBit)
                        next_state = CSM_ST_END_ALIGN;
                    else
                    begin
                        next_state = CSM_ST_IDLE;
                        finishing = 1'b1;
                    end
                end
                CSM_ST_END_ALIGN:
                begin
                    if (qualEdge)
                    begin
                        next_state = CSM_ST_IDLE;
                        finishing = 1'b1;
                    end
                end
                default: next_state = CSM_ST_IDLE;
            endcase
        end
    end

    wire next_holdActive = (next_state == CSM_ST_HOLD) || (next_state == CSM_ST_END_ALIGN);
    // R07 R06 R09 only unmasked outputs are held low
    wire [5:0] next_holdLow = next_holdActive ? ~maskField : 6'h00;
    // R08 delay loads only into outputs that took part
    wire [5:0] next_apply = finishing ? ~maskField : 6'h00;

    // R10 R11 sync pin source and polarity
    wire syncSrcBit = (syncSrcField == `CSM_SYNC_SRC_READBACK) ? readbackS : 1'b0;
    wire syncLevel = pinLevel(syncTypeField, syncSrcBit);

    // R20 lock pin source; reserved code reads low
    wire [18:0] lockSrcVec = {tapS, convS[3], convS[2], convS[1], readbackS, 1'b0, convS[0],
                              holdS, &lockS, lockS[1], lockS[0], 1'b0};
    wire lockSrcBit = (ldSrcField <= `CSM_LD_SRC_LAST) ? lockSrcVec[ldSrcField] : 1'b0;
    // R21 lock pin polarity by type
    wire lockLevel = pinLevel(ldTypeField, lockSrcBit);

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            regModeSync <= `CSM_MODE_SYNC_RESET;
            regLockPin <= `CSM_LOCK_PIN_RESET;
        end
        else
        begin
            if (wrModeSync)
                regModeSync <= shiftWord;
            if (wrLockPin)
                regLockPin <= shiftWord;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            leD <= 1'b0;
            pendingAuto <= 1'b0;
            reqPulse <= 1'b0;
            qualPrev <= 1'b0;
        end
        else
        begin
            leD <= leS;
            pendingAuto <= wrDelay || (pendingAuto && !leFall);
            reqPulse <= next_req;
            qualPrev <= qualSel;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state <= CSM_ST_IDLE;
            cnt <= 3'h0;
            holdActive <= 1'b0;
            outputHoldLow <= 6'h00;
            delayApply <= 6'h00;
        end
        else
        begin
            state <= next_state;
            cnt <= next_cnt;
            holdActive <= next_holdActive;
            outputHoldLow <= next_holdLow;
            delayApply <= next_apply;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            firstLoopPowerDown <= 1'b0;
            secondLoopPowerDown <= 1'b0;
            refFromOscInput <= 1'b0;
            distributionMode <= 1'b0;
            zeroDelayEnable <= 1'b0;
            externalVcoSelect <= 1'b0;
            modeReserved <= 1'b0;
            oscAmpEnable <= 1'b0;
            syncEnable <= 1'b1;
        end
        else
        begin
            firstLoopPowerDown <= next_firstLoopPowerDown;
            secondLoopPowerDown <= next_secondLoopPowerDown;
            refFromOscInput <= next_refFromOscInput;
            distributionMode <= isDist;
            zeroDelayEnable <= isZeroDelay;
            externalVcoSelect <= next_externalVco;
            modeReserved <= !isKnown;
            // R19 crystal amplifier power
            oscAmpEnable <= oscAmpBit;
            syncEnable <= enSyncBit;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            syncPinOut <= 1'b0;
            syncPinOe_n <= 1'b1;
            syncPinPullUp <= 1'b0;
            syncPinPullDown <= 1'b0;
            lockPinOut <= 1'b0;
            lockPinOe_n <= 1'b0;
        end
        else
        begin
            // R17 pin kind from type field
            syncPinOut <= syncLevel;
            syncPinOe_n <= pinOeN(syncTypeField, syncLevel);
            syncPinPullUp <= syncTypeField == `CSM_PIN_IN_PU;
            syncPinPullDown <= syncTypeField == `CSM_PIN_IN_PD;
            lockPinOut <= lockLevel;
            lockPinOe_n <= pinOeN(ldTypeField, lockLevel);
        end
    end

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    sequence s_wrEnRise;
        enRise && !shiftWord[`CSM_QUAL_BIT];
    endsequence
    sequence s_wrPolToggle;
        polToggle && shiftWord[`CSM_EN_SYNC_BIT] && !shiftWord[`CSM_QUAL_BIT];
    endsequence
    sequence s_holdStart;
        $rose(holdActive) && !qualBit;
    endsequence

    property p_dual_mode;
        (modeField == `CSM_MODE_DUAL_INT) |=> !firstLoopPowerDown && !externalVcoSelect && !modeReserved;
    endproperty
    a_dual_mode: assert property (p_dual_mode) else $error("dual loop decode wrong"); // R01
    property p_single_mode;
        isSingle |=> firstLoopPowerDown && refFromOscInput && !secondLoopPowerDown;
    endproperty
    a_single_mode: assert property (p_single_mode) else $error("single loop decode wrong"); // R02
    property p_dist_mode;
        (modeField == `CSM_MODE_DIST) |=> distributionMode && secondLoopPowerDown && !zeroDelayEnable;
    endproperty
    a_dist_mode: assert property (p_dist_mode) else $error("distribution decode wrong"); // R03
    property p_sync_off;
        !enSyncBit |=> (outputHoldLow == 6'h00) && (delayApply == 6'h00);
    endproperty
    a_sync_off: assert property (p_sync_off) else $error("sync acted while disabled"); // R04
    property p_en_rise;
        s_wrEnRise |-> ##2 holdActive && (outputHoldLow == ~maskField);
    endproperty
    a_en_rise: assert property (p_en_rise) else $error("enable rise gave no sync"); // R05
    property p_mask_keeps;
        (outputHoldLow & $past(maskField)) == 6'h00;
    endproperty
    a_mask_keeps: assert property (p_mask_keeps) else $error("masked output held low"); // R06
    property p_hold_length;
        s_holdStart |-> holdActive [*4];
    endproperty
    a_hold_length: assert property (p_hold_length) else $error("sync hold too short"); // R07
    property p_apply_end;
        ($fell(holdActive) && $past(enSyncBit)) |-> (delayApply == ~$past(maskField)) ##1 (delayApply == 6'h00);
    endproperty
    a_apply_end: assert property (p_apply_end) else $error("delay apply wrong at sync end"); // R08
    property p_pin_inverted;
        (syncTypeField == `CSM_PIN_OUT_INV && syncSrcField == `CSM_SYNC_SRC_LOW) |=> syncPinOut && !syncPinOe_n;
    endproperty
    a_pin_inverted: assert property (p_pin_inverted) else $error("inverted sync pin wrong"); // R11
    property p_qual_start;
        ($rose(holdActive) && qualBit) |-> $past(qualEdge);
    endproperty
    a_qual_start: assert property (p_qual_start) else $error("qualified sync started off edge"); // R12
    property p_pin_sense;
        (!syncOutType && (pinS ^ polBit) && enSyncBit && !qualBit) |=> holdActive;
    endproperty
    a_pin_sense: assert property (p_pin_sense) else $error("asserted pin did not hold"); // R14
    property p_pol_toggle;
        s_wrPolToggle |-> ##2 holdActive;
    endproperty
    a_pol_toggle: assert property (p_pol_toggle) else $error("polarity toggle gave no sync"); // R15
    property p_auto_sync;
        (autoFire && enSyncBit && !qualBit) |=> reqPulse ##1 holdActive;
    endproperty
    a_auto_sync: assert property (p_auto_sync) else $error("auto sync missing"); // R16
    property p_out_type_zero;
        (syncOutType && polBit && enSyncBit && !qualBit) |=> holdActive;
    endproperty
    a_out_type_zero: assert property (p_out_type_zero) else $error("output type not read as zero"); // R18
    property p_lock_inv;
        (ldTypeField == `CSM_PIN_OUT_INV && ldSrcField == 5'h00) |=> lockPinOut && !lockPinOe_n;
    endproperty
    a_lock_inv: assert property (p_lock_inv) else $error("lock pin polarity wrong"); // R21

endmodule : csm_top
`default_nettype wire

//--- test/csm_host_model.sv
`default_nettype none
module csm_host_model
(
    input wire logic go,
    input wire logic [31:0] word,
    output logic serialClk,
    output logic serialData,
    output logic serialLatchEnable,
    output logic done
);
    timeunit 1ns;
    timeprecision 1ns;
    initial
    begin
        {serialClk, serialData, serialLatchEnable, done} = 4'h0;
        forever
        begin
            @(posedge go);
            done = 1'h0;
            #11;
            for (int i = 31; i >= 0; i--)
            begin
                serialData = word[i];
                #32 serialClk = 1'h1;
                #32 serialClk = 1'h0;
            end
            // released data shows the inverse, clock stands still
            serialData = ~word[0];
            #7 serialLatchEnable = 1'h1;
            #300 serialLatchEnable = 1'h0;
            #300 done = 1'h1;
        end
    end
endmodule : csm_host_model
`default_nettype wire

//--- test/clock_sync_mode_control_bench.sv
`default_nettype none
module clock_sync_mode_control_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_sys, rst_n, syncPinIn, holdoverStatus, readbackData, go, clr;
    logic [5:0] qualClk, holdSeen, delaySeen, outputHoldLow, delayApply;
    logic [2:0] feedbackSelect;
    logic [1:0] lockDetect;
    logic [3:0] converterStatus;
    logic [7:0] loopDividerTap;
    logic [31:0] word;
    logic serialClk, serialData, serialLatchEnable, done, firstLoopPowerDown, secondLoopPowerDown;
    logic refFromOscInput, distributionMode, zeroDelayEnable, externalVcoSelect, modeReserved;
    logic oscAmpEnable, syncEnable, syncPinOut, syncPinOe_n, syncPinPullUp, syncPinPullDown;
    logic lockPinOut, lockPinOe_n;
    int miscompares, checks;
    csm_top uut
    (
        .clk_sys, .rst_n, .serialClk, .serialData, .serialLatchEnable, .syncPinIn, .qualClk, .feedbackSelect,
        .lockDetect, .holdoverStatus, .converterStatus, .loopDividerTap, .readbackData, .firstLoopPowerDown,
        .secondLoopPowerDown, .refFromOscInput, .distributionMode, .zeroDelayEnable, .externalVcoSelect,
        .modeReserved, .oscAmpEnable, .syncEnable, .outputHoldLow, .delayApply, .syncPinOut, .syncPinOe_n,
        .syncPinPullUp, .syncPinPullDown, .lockPinOut, .lockPinOe_n
    );
    csm_host_model host (.go, .word, .serialClk, .serialData, .serialLatchEnable, .done);
    initial
    begin
        clk_sys = 1'h0;
        forever #25 clk_sys = ~clk_sys;
    end
    always #75 qualClk <= ~qualClk;
    always @(posedge clk_sys)
    begin
        holdSeen <= clr ? 6'h00 : holdSeen | outputHoldLow;
        delaySeen <= clr ? 6'h00 : delaySeen | delayApply;
    end
    function automatic logic [31:0] m11(input logic [4:0] md, input logic en, input logic [5:0] mk,
        input logic [1:0] sr, input logic pl, input logic au, input logic [2:0] ty, input logic am);
        return {md, en, mk, sr, 1'h0, pl, au, ty, 6'h00, am, 5'h0B};
    endfunction : m11
    // p: ld[1:0], holdover, readback, converter[7:4], taps[15:8]
    function automatic logic srcOf(input int c, input logic [15:0] p);
        if (c == 1 || c == 2)
            return p[c-1];
        if (c == 3)
            return p[0] & p[1];
        if (c == 4)
            return p[2];
        if (c == 5)
            return p[4];
        return (c == 7) ? p[3] : (c == 0) ? 1'h0 : p[c-3];
    endfunction : srcOf
    task chk(input string n, input logic [31:0] e, input logic [31:0] s);
        checks++;
        if (s !== e)
        begin
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
            miscompares++;
        end
    endtask : chk
    task automatic wr(input logic [31:0] w);
        int n;
        n = 0;
        word <= w;
        go <= 1'h1;
        clr <= 1'h1;
        @(posedge clk_sys);
        clr <= 1'h0;
        while (done !== 1'h1 && n < 100)
        begin
            @(posedge clk_sys);
            n++;
        end
        go <= 1'h0;
        chk("frameDone", 0, n >= 100);
        repeat (12) @(posedge clk_sys);
    endtask : wr
    task conclude;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : conclude
    task automatic t_modes;
        logic [4:0] cs [8] = '{5'h00, 5'h02, 5'h03, 5'h05, 5'h06, 5'h08, 5'h0B, 5'h10};
        logic s;
        for (int i = 0; i < 8; i++)
        begin
            s = cs[i] inside {5'h06, 5'h08, 5'h0B};
            wr(m11(cs[i], 1'h1, 6'h00, 2'h0, 1'h0, 1'h0, 3'h0, i[0]));
            chk("decode", {cs[i] == 5'h10, cs[i] inside {5'h02, 5'h05, 5'h08}, cs[i] inside {5'h03, 5'h05, 5'h0B}},
                {distributionMode, zeroDelayEnable, externalVcoSelect});
            chk("extra", {1'h0, i[0]}, {modeReserved, oscAmpEnable});
            if (cs[i] != 5'h10)
                chk("loops", {s, 1'h0, s}, {firstLoopPowerDown, secondLoopPowerDown, refFromOscInput});
        end
    endtask : t_modes
    task t_sync_pin;
        wr(m11(5'h00, 1'h1, 6'h15, 2'h0, 1'h0, 1'h0, 3'h3, 1'h0));
        chk("pinLow", 8'h00, {syncPinOut, syncPinOe_n, holdSeen});
        wr(m11(5'h00, 1'h1, 6'h15, 2'h0, 1'h1, 1'h0, 3'h4, 1'h0));
        chk("pinInv", 8'hAA, {syncPinOut, syncPinOe_n, outputHoldLow});
        wr(m11(5'h00, 1'h1, 6'h15, 2'h0, 1'h0, 1'h0, 3'h3, 1'h0));
        chk("release", 12'h02A, {outputHoldLow, delaySeen});
        readbackData <= 1'h1;
        wr(m11(5'h00, 1'h1, 6'h15, 2'h3, 1'h0, 1'h0, 3'h3, 1'h0));
        chk("readback", 2'h2, {syncPinOut, syncPinOe_n});
        wr(m11(5'h00, 1'h1, 6'h0C, 2'h0, 1'h0, 1'h0, 3'h1, 1'h0));
        chk("pullUp", 3'h5, {syncPinPullUp, syncPinPullDown, syncPinOe_n});
        syncPinIn <= 1'h1;
        repeat (8) @(posedge clk_sys);
        chk("pinHold", 6'h33, outputHoldLow);
        syncPinIn <= 1'h0;
        repeat (10) @(posedge clk_sys);
        chk("pinFree", 6'h00, outputHoldLow);
        syncPinIn <= 1'h1;
        wr(m11(5'h00, 1'h1, 6'h0C, 2'h0, 1'h1, 1'h0, 3'h2, 1'h0));
        chk("pullDown", 9'h0C0, {syncPinPullUp, syncPinPullDown, syncPinOe_n, outputHoldLow});
        syncPinIn <= 1'h0;
        repeat (8) @(posedge clk_sys);
        chk("lowHold", 6'h33, outputHoldLow);
        wr(m11(5'h00, 1'h1, 6'h30, 2'h0, 1'h0, 1'h0, 3'h0, 1'h0));
    endtask : t_sync_pin
    task t_events;
        wr(m11(5'h00, 1'h0, 6'h30, 2'h0, 1'h0, 1'h0, 3'h0, 1'h0));
        syncPinIn <= 1'h1;
        repeat (8) @(posedge clk_sys);
        syncPinIn <= 1'h0;
        repeat (10) @(posedge clk_sys);
        chk("disabled", 13'h0000, {syncEnable, holdSeen, delaySeen});
        wr(m11(5'h00, 1'h1, 6'h30, 2'h0, 1'h0, 1'h0, 3'h0, 1'h0));
        chk("enRise", 6'h0F, holdSeen);
        wr(m11(5'h00, 1'h1, 6'h00, 2'h0, 1'h0, 1'h1, 3'h0, 1'h0));
        wr(32'h0000_0003);
        chk("autoSync", 6'h3F, delaySeen);
        wr(32'h0000_0007);
        chk("noAuto", 6'h00, delaySeen);
        // out_two_divider_powerdown stays 0 elsewhere while qualifying
        feedbackSelect <= 3'h6;
        wr(m11(5'h00, 1'h1, 6'h00, 2'h0, 1'h0, 1'h0, 3'h0, 1'h0) | 32'h0002_0000);
        syncPinIn <= 1'h1;
        repeat (6) @(posedge clk_sys);
        syncPinIn <= 1'h0;
        repeat (20) @(posedge clk_sys);
        chk("qualWait", 6'h00, holdSeen);
        feedbackSelect <= 3'h0;
        repeat (20) @(posedge clk_sys);
        chk("qualGo", 6'h3F, holdSeen);
    endtask : t_events
    task automatic t_lock;
        logic [15:0] ps [3] = '{16'hA5C7, 16'h5A38, 16'h3C95};
        logic inv;
        // reserved code 6 skipped; 17 and 18 allowed as holdover source is elsewhere
        for (int c = 0; c <= 18; c++)
        begin
            inv = !c[0];
            if (c != 6)
            begin
                wr({c[4:0], inv ? 3'h4 : 3'h3, 24'h00_000C});
                for (int k = 0; k < 3; k++)
                begin
                    {loopDividerTap, converterStatus, readbackData, holdoverStatus, lockDetect} <= ps[k];
                    repeat (5) @(posedge clk_sys);
                    chk("lockPin", {srcOf(c, ps[k]) ^ inv, 1'h0}, {lockPinOut, lockPinOe_n});
                end
            end
        end
    endtask : t_lock
    initial
    begin
        {rst_n, syncPinIn, holdoverStatus, readbackData, go, clr, lockDetect, converterStatus} = '0;
        {qualClk, feedbackSelect, loopDividerTap, word} = '0;
        miscompares = 0;
        checks = 0;
        repeat (3) @(posedge clk_sys);
        rst_n <= 1'h1;
        repeat (4) @(posedge clk_sys);
        chk("reset", 8'hC0, {syncEnable, syncPinOe_n, lockPinOut, lockPinOe_n, firstLoopPowerDown,
            distributionMode, modeReserved, oscAmpEnable});
        t_modes();
        t_sync_pin();
        t_events();
        t_lock();
        conclude();
    end
    initial
    begin
        #2000000;
        miscompares++;
        conclude();
    end
endmodule : clock_sync_mode_control_bench
`default_nettype wire
